// ---- verilog/asws_top.sv ----
// async wait, strobe extension, page read, bus parking and interrupt control
//
// Summary of operation
// - nand status shows synchronised raw wait level
// - wait rising edge sets wait rise flag
// - polarity never affects status or rise flag
// - extended wait watches pin per chip select
// - stretch strobe, then resume final strobe cycle
// - extension bounded, expiry forces hold phase
// - expiry records async timeout event
// - polarity one waits high, zero waits low
// - per chip select nor page mode reads
// - park bus with last write data
// - self refresh read leaves bus tristated
// - hard reset all, machine reset control only
// - init sequence starts when reset releases
// - machine reset discards the access in flight and its data
// - all interrupt sources merge to one output
// - raw always sets, masked only when enabled
// - enable set and clear, both read state
`timescale 1ns/100ps
`default_nettype none
module asws_top (
  // clock and resets
  input  wire  logic                              CLOCK_IN,
  input  wire  logic                              RESETN_IN,
  input  wire  logic                              SM_RESETN_IN,
  // memory pins
  input  wire  logic                              READY_WAIT_PIN_IN,
  input  wire  logic [asws_pkg::DATA_W-1:0]       DATA_IN,
  output var   logic [asws_pkg::DATA_W-1:0]       DATA_OUT,
  output var   logic                              DATA_OE_OUT,
  output var   logic                              STROBE_OUT,
  output var   logic [asws_pkg::CS_N-1:0]         CS_SEL_OUT,
  output var   logic [asws_pkg::WORD_W-1:0]       PAGE_WORD_OUT,
  // configuration
  input  wire  logic                              NAND_MODE_IN,
  input  wire  logic                              WAIT_POLARITY_IN,
  input  wire  logic [asws_pkg::EXT_W-1:0]        MAX_STROBE_EXTENSION_IN,
  input  wire  logic [asws_pkg::CS_N-1:0]         EXT_WAIT_ENABLE_IN,
  input  wire  logic [asws_pkg::CS_N-1:0]         PAGE_READ_ENABLE_IN,
  input  wire  logic [asws_pkg::CS_N-1:0]         PAGE_SIZE_SEL_IN,
  input  wire  logic [asws_pkg::PDEL_W-1:0]       PAGE_ACCESS_DELAY_IN,
  input  wire  logic                              SELF_REFRESH_IN,
  // access request
  input  wire  logic                              ACCESS_START_IN,
  input  wire  logic                              ACCESS_READ_IN,
  input  wire  logic [asws_pkg::CS_W-1:0]         ACCESS_CS_IN,
  input  wire  logic [asws_pkg::STRB_W-1:0]       STROBE_LEN_IN,
  input  wire  logic [asws_pkg::DATA_W-1:0]       WRITE_DATA_IN,
  // access answer
  output var   logic                              READY_OUT,
  output var   logic                              ACCESS_DONE_OUT,
  output var   logic [asws_pkg::DATA_W-1:0]       READ_DATA_OUT,
  output var   logic                              READ_VALID_OUT,
  // interrupt control and status
  input  wire  logic [asws_pkg::IRQ_N-1:0]        IRQ_RAW_CLEAR_IN,
  input  wire  logic [asws_pkg::IRQ_N-1:0]        IRQ_ENABLE_SET_IN,
  input  wire  logic [asws_pkg::IRQ_N-1:0]        IRQ_ENABLE_CLEAR_IN,
  output var   logic [asws_pkg::IRQ_N-1:0]        IRQ_RAW_OUT,
  output var   logic [asws_pkg::IRQ_N-1:0]        IRQ_MASKED_OUT,
  output var   logic [asws_pkg::IRQ_N-1:0]        IRQ_ENABLE_OUT,
  output var   logic                              IRQ_OUT,
  output var   logic                              NAND_STATUS_OUT
);
  import asws_pkg::*;

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    asws_state_t       state;      // control state
    logic [INIT_W-1:0] init_cnt;   // init sequence progress
    logic [STRB_W-1:0] phase_cnt;  // cycles left in strobe or hold
    logic [PDEL_W-1:0] pdel_cnt;   // cycles left for a page word
    logic [WORD_W-1:0] word;       // current word within page
    logic [WORD_W-1:0] word_last;  // last word index of this page
    logic [CS_W-1:0]   cs;         // chip select of current access
    logic              rd;         // current access is a read
    logic              page;       // current read uses page mode
    logic              sr_read;    // read started in self refresh
    logic              strobe;     // strobe pin
    logic [CS_N-1:0]   cs_sel;     // one hot chip select pins
    logic              oe;         // data bus drive enable
    logic [DATA_W-1:0] park;       // last write data
    logic [DATA_W-1:0] rdata;      // latched read word
    logic              rvalid;     // read word pulse
    logic              done;       // access finished pulse
    logic              ready;      // able to take a request
    logic [IRQ_N-1:0]  irq_raw;    // raw event flags
    logic [IRQ_N-1:0]  irq_masked; // enabled event flags
    logic [IRQ_N-1:0]  irq_en;     // source enables
    logic              irq;        // merged interrupt
    logic              nand_stat;  // nand busy status
  } asws_core_t;

  asws_core_t cur;
  asws_core_t next_cur;

  // ----------------------------------------------------------------
  // wait pin conditioning and extension counter
  // ----------------------------------------------------------------
  asws_wait_if wif ();

  // pin is asynchronous to us, so nothing reads it raw
  asws_wait_sync u_sync (
    .clk   (CLOCK_IN),
    .rst_n (RESETN_IN),
    .pin   (READY_WAIT_PIN_IN),
    .wif   (wif.sync_mp)
  );

  asws_ext_counter u_ext (
    .clk   (CLOCK_IN),
    .rst_n (RESETN_IN),
    .wif   (wif.ext_mp)
  );

  logic             wait_active;   // device asks for more strobe
  logic             start_ok;      // request accepted this cycle
  logic             timeout_ev;    // extension limit reached
  logic [IRQ_N-1:0] irq_ev;        // events of this cycle

  // polarity only matters for stretching, never for status or flags
  assign wait_active = (wif.wait_level == WAIT_POLARITY_IN);
  assign start_ok    = cur.ready && ACCESS_START_IN;
  assign timeout_ev  = (cur.state == ASWS_EXTEND) && wif.ext_expired;

  // counter runs only in extension, restarts with every access
  assign wif.ext_run   = (cur.state == ASWS_EXTEND);
  assign wif.ext_clear = start_ok;
  assign wif.ext_max   = MAX_STROBE_EXTENSION_IN;

  // ----------------------------------------------------------------
  // interrupt event vector
  // ----------------------------------------------------------------
  always_comb begin
    irq_ev             = '0;
    irq_ev[IRQ_WR_BIT] = wif.wait_rise;
    irq_ev[IRQ_AT_BIT] = timeout_ev;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur        = cur;
    next_cur.rvalid = 1'b0;
    next_cur.done   = 1'b0;

    // interrupt flags; a new event wins over a clear in the same cycle
    next_cur.irq_raw    = (cur.irq_raw & ~IRQ_RAW_CLEAR_IN) | irq_ev;
    next_cur.irq_masked = (cur.irq_masked & ~IRQ_RAW_CLEAR_IN) | (irq_ev & cur.irq_en);
    // simultaneous set and clear of an enable leaves it enabled
    next_cur.irq_en     = (cur.irq_en & ~IRQ_ENABLE_CLEAR_IN) | IRQ_ENABLE_SET_IN;
    next_cur.irq        = |next_cur.irq_masked;
    // status follows the true pin level, outside nand mode it reads zero
    next_cur.nand_stat  = NAND_MODE_IN & wif.wait_level;

    case (cur.state)
      // init sequence, runs by itself after any reset release
      ASWS_INIT: begin
        if (cur.init_cnt == INIT_LAST) begin
          next_cur.state = ASWS_IDLE;
          next_cur.ready = 1'b1;
        end else begin
          next_cur.init_cnt = cur.init_cnt + 8'h01;
        end
      end

      // idle, bus parked unless a self refresh read left it floating
      ASWS_IDLE: begin
        if (start_ok) begin
          next_cur.state     = ASWS_STROBE;
          next_cur.ready     = 1'b0;
          next_cur.cs        = ACCESS_CS_IN;
          next_cur.cs_sel    = CS_N'(1) << ACCESS_CS_IN;
          next_cur.rd        = ACCESS_READ_IN;
          next_cur.strobe    = 1'b1;
          next_cur.word      = '0;
          // zero length is treated as one cycle of strobe
          next_cur.phase_cnt = (STROBE_LEN_IN == '0) ? '0 : STROBE_LEN_IN - 6'h01;
          next_cur.page      = ACCESS_READ_IN && PAGE_READ_ENABLE_IN[ACCESS_CS_IN];
          next_cur.word_last = PAGE_SIZE_SEL_IN[ACCESS_CS_IN] ? PAGE_LARGE : PAGE_SMALL;
          if (ACCESS_READ_IN) begin
            // release the bus only for reads
            next_cur.oe      = 1'b0;
            next_cur.sr_read = SELF_REFRESH_IN;
          end else begin
            next_cur.oe      = 1'b1;
            next_cur.park    = WRITE_DATA_IN;
            next_cur.sr_read = 1'b0;
          end
        end
      end

      // programmed strobe period
      ASWS_STROBE: begin
        if (cur.phase_cnt != '0) begin
          next_cur.phase_cnt = cur.phase_cnt - 6'h01;
        end else if (EXT_WAIT_ENABLE_IN[cur.cs] && wait_active && !cur.page) begin
          // device holds off the last strobe cycle
          next_cur.state = ASWS_EXTEND;
        end else if (cur.rd && cur.page && (cur.word != cur.word_last)) begin
          // first page word, then walk the page with the short delay
          next_cur.rdata     = DATA_IN;
          next_cur.rvalid    = 1'b1;
          next_cur.word      = cur.word + 3'h1;
          next_cur.pdel_cnt  = (PAGE_ACCESS_DELAY_IN == '0) ? '0 : PAGE_ACCESS_DELAY_IN - 4'h1;
          next_cur.state     = ASWS_PAGE;
        end else begin
          if (cur.rd) begin
            next_cur.rdata  = DATA_IN;
            next_cur.rvalid = 1'b1;
            // repark right after the last word, not after self refresh
            next_cur.oe     = !cur.sr_read;
          end
          next_cur.strobe    = 1'b0;
          next_cur.phase_cnt = HOLD_LAST;
          next_cur.state     = ASWS_HOLD;
        end
      end

      // extra strobe cycles while the device keeps wait active
      ASWS_EXTEND: begin
        if (wif.ext_expired) begin
          // give up on the device, go to hold whatever the pin says
          next_cur.strobe    = 1'b0;
          next_cur.phase_cnt = HOLD_LAST;
          next_cur.state     = ASWS_HOLD;
          if (cur.rd) begin
            next_cur.rdata  = DATA_IN;
            next_cur.rvalid = 1'b1;
            next_cur.oe     = !cur.sr_read;
          end
        end else if (!wait_active) begin
          // back to the final programmed strobe cycle
          next_cur.phase_cnt = '0;
          next_cur.state     = ASWS_STROBE;
        end
      end

      // page mode: each further word after the page access delay
      ASWS_PAGE: begin
        if (cur.pdel_cnt != '0) begin
          next_cur.pdel_cnt = cur.pdel_cnt - 4'h1;
        end else begin
          next_cur.rdata  = DATA_IN;
          next_cur.rvalid = 1'b1;
          if (cur.word == cur.word_last) begin
            next_cur.strobe    = 1'b0;
            next_cur.oe        = !cur.sr_read;
            next_cur.phase_cnt = HOLD_LAST;
            next_cur.state     = ASWS_HOLD;
          end else begin
            next_cur.word     = cur.word + 3'h1;
            next_cur.pdel_cnt = (PAGE_ACCESS_DELAY_IN == '0) ? '0 : PAGE_ACCESS_DELAY_IN - 4'h1;
          end
        end
      end

      // hold, then chip select drops and a new request is taken
      ASWS_HOLD: begin
        if (cur.phase_cnt != '0) begin
          next_cur.phase_cnt = cur.phase_cnt - 6'h01;
        end else begin
          next_cur.cs_sel = '0;
          next_cur.done   = 1'b1;
          next_cur.ready  = 1'b1;
          next_cur.state  = ASWS_IDLE;
        end
      end

      default: begin
        next_cur.state = ASWS_INIT;
      end
    endcase

    // machine reset: control restarts, flags, enables and park data stay
    if (!SM_RESETN_IN) begin
      // the access in flight and its data are dropped
      next_cur.state     = ASWS_INIT;
      next_cur.init_cnt  = '0;
      next_cur.ready     = 1'b0;
      next_cur.strobe    = 1'b0;
      next_cur.cs_sel    = '0;
      next_cur.phase_cnt = '0;
      next_cur.pdel_cnt  = '0;
      next_cur.word      = '0;
      next_cur.rvalid    = 1'b0;
      next_cur.done      = 1'b0;
      next_cur.oe        = 1'b1;
      next_cur.sr_read   = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register, hard reset clears every field except oe, set to one, and word_last, set to PAGE_SMALL
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cur            <= '0;
      cur.state      <= ASWS_INIT;
      cur.oe         <= 1'b1;
      cur.park       <= PARK_RST;
      cur.word_last  <= PAGE_SMALL;
      cur.irq_raw    <= IRQ_RST;
      cur.irq_masked <= IRQ_RST;
      cur.irq_en     <= IRQ_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign DATA_OUT        = cur.park;
  assign DATA_OE_OUT     = cur.oe;
  assign STROBE_OUT      = cur.strobe;
  assign CS_SEL_OUT      = cur.cs_sel;
  assign PAGE_WORD_OUT   = cur.word;
  assign READY_OUT       = cur.ready;
  assign ACCESS_DONE_OUT = cur.done;
  assign READ_DATA_OUT   = cur.rdata;
  assign READ_VALID_OUT  = cur.rvalid;
  assign IRQ_RAW_OUT     = cur.irq_raw;
  assign IRQ_MASKED_OUT  = cur.irq_masked;
  assign IRQ_ENABLE_OUT  = cur.irq_en;
  assign IRQ_OUT         = cur.irq;
  assign NAND_STATUS_OUT = cur.nand_stat;

endmodule
`default_nettype wire

// ---- verilog/asws_pkg.sv ----
// shared constants and types of the async wait and strobe control block
`default_nettype none
package asws_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W  = 16;  // memory data bus width
  localparam int unsigned CS_N    = 4;   // asynchronous chip selects
  localparam int unsigned CS_W    = 2;   // chip select index width
  localparam int unsigned STRB_W  = 6;   // strobe and hold length width
  localparam int unsigned EXT_W   = 8;   // extension counter width
  localparam int unsigned PDEL_W  = 4;   // page access delay width
  localparam int unsigned WORD_W  = 3;   // word index inside a page
  localparam int unsigned INIT_W  = 8;   // init sequence counter width
  localparam int unsigned IRQ_N   = 2;   // interrupt sources

  // ----------------------------------------------------------------
  // interrupt bit positions
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_WR_BIT = 0;  // wait rise
  localparam int unsigned IRQ_AT_BIT = 1;  // async timeout

  // ----------------------------------------------------------------
  // cycle counts and values after reset
  // ----------------------------------------------------------------
  localparam logic [INIT_W-1:0] INIT_LAST   = 8'h0F;  // init takes 16 cycles
  localparam logic [STRB_W-1:0] HOLD_LAST   = 6'h01;  // hold takes 2 cycles
  localparam logic [WORD_W-1:0] PAGE_SMALL  = 3'h3;   // 4 word page, last index
  localparam logic [WORD_W-1:0] PAGE_LARGE  = 3'h7;   // 8 word page, last index
  localparam logic [IRQ_N-1:0]  IRQ_RST     = 2'h0;   // flags and enables
  localparam logic [DATA_W-1:0] PARK_RST    = 16'h0000;

  // ----------------------------------------------------------------
  // control states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ASWS_INIT,
    ASWS_IDLE,
    ASWS_STROBE,
    ASWS_EXTEND,
    ASWS_PAGE,
    ASWS_HOLD
  } asws_state_t;

endpackage
`default_nettype wire

// ---- verilog/asws_wait_if.sv ----
// interface between the control core, wait synchroniser and extension counter
`timescale 1ns/100ps
`default_nettype none
interface asws_wait_if;
  import asws_pkg::*;
  logic             wait_level;   // synchronised pin level
  logic             wait_rise;    // one cycle pulse on rising edge
  logic             ext_run;      // counting extension cycles
  logic             ext_clear;    // restart count at access start
  logic [EXT_W-1:0] ext_max;      // allowed extension length
  logic             ext_expired;  // count reached the limit

  modport sync_mp (output wait_level, output wait_rise);
  modport ext_mp  (input ext_run, input ext_clear, input ext_max, output ext_expired);
  modport core_mp (input wait_level, input wait_rise, input ext_expired,
                   output ext_run, output ext_clear, output ext_max);
endinterface
`default_nettype wire

// ---- verilog/asws_wait_sync.sv ----
// two stage synchroniser and rise detector for the ready/wait pin
`timescale 1ns/100ps
`default_nettype none
module asws_wait_sync (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  pin,
  asws_wait_if.sync_mp wif
);
  import asws_pkg::*;

  typedef struct packed {
    logic meta;   // first stage, read only by second
    logic sync;   // stable level
    logic prev;   // delayed level for edges
  } asws_sync_t;

  asws_sync_t cur;
  asws_sync_t next_cur;

  // shift chain; the edge compare never looks at the first stage
  always_comb begin
    next_cur      = cur;
    next_cur.meta = pin;
    next_cur.sync = cur.meta;
    next_cur.prev = cur.sync;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '1;
    end else begin
      cur <= next_cur;
    end
  end

  assign wif.wait_level = cur.sync;
  assign wif.wait_rise  = cur.sync & ~cur.prev;
endmodule
`default_nettype wire

// ---- verilog/asws_ext_counter.sv ----
// bounded strobe extension counter
`timescale 1ns/100ps
`default_nettype none
module asws_ext_counter (
  input  wire logic  clk,
  input  wire logic  rst_n,
  asws_wait_if.ext_mp wif
);
  import asws_pkg::*;

  typedef struct packed {
    logic [EXT_W-1:0] count;  // extension cycles spent this access
  } asws_cnt_t;

  asws_cnt_t cur;
  asws_cnt_t next_cur;

  // count persists across re-extensions so the whole access stays bounded
  always_comb begin
    next_cur = cur;
    if (wif.ext_clear) begin
      next_cur.count = '0;
    end else if (wif.ext_run && (cur.count != wif.ext_max)) begin
      next_cur.count = cur.count + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign wif.ext_expired = wif.ext_run && (cur.count == wif.ext_max);
endmodule
`default_nettype wire

// ---- bench/asws_asserts.sv ----
// port-level checker for the async wait and strobe block
`timescale 1ns/100ps
`default_nettype none
module asws_asserts
  import asws_pkg::*;
(
  // clock, resets and pins
  input wire logic             CLOCK_IN,
  input wire logic             RESETN_IN,
  input wire logic             SM_RESETN_IN,
  input wire logic             READY_WAIT_PIN_IN,
  input wire logic             NAND_MODE_IN,
  // access side
  input wire logic             ACCESS_START_IN,
  input wire logic             ACCESS_READ_IN,
  input wire logic             READY_OUT,
  input wire logic             STROBE_OUT,
  input wire logic             DATA_OE_OUT,
  // interrupt side
  input wire logic [IRQ_N-1:0] IRQ_RAW_CLEAR_IN,
  input wire logic [IRQ_N-1:0] IRQ_ENABLE_SET_IN,
  input wire logic [IRQ_N-1:0] IRQ_ENABLE_CLEAR_IN,
  input wire logic [IRQ_N-1:0] IRQ_RAW_OUT,
  input wire logic [IRQ_N-1:0] IRQ_MASKED_OUT,
  input wire logic [IRQ_N-1:0] IRQ_ENABLE_OUT,
  input wire logic             IRQ_OUT,
  input wire logic             NAND_STATUS_OUT
);
  // checks rest during either reset
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN || !SM_RESETN_IN);
  chk_irq_merge:
    assert property (IRQ_OUT == (|IRQ_MASKED_OUT)) else $error("irq out not or of masked");
  chk_masked_needs_enable:
    assert property ((IRQ_MASKED_OUT & ~$past(IRQ_MASKED_OUT) & ~$past(IRQ_ENABLE_OUT)) == '0)
      else $error("masked flag set while disabled");
  chk_enable_set:
    assert property ((IRQ_ENABLE_SET_IN != '0) |=> ((IRQ_ENABLE_OUT & $past(IRQ_ENABLE_SET_IN))
      == $past(IRQ_ENABLE_SET_IN))) else $error("enable set lost");
  chk_enable_clear:
    assert property ((IRQ_ENABLE_CLEAR_IN[IRQ_WR_BIT] && !IRQ_ENABLE_SET_IN[IRQ_WR_BIT])
      |=> !IRQ_ENABLE_OUT[IRQ_WR_BIT]) else $error("enable clear lost");
  chk_status_level:
    assert property ((NAND_MODE_IN && $stable(READY_WAIT_PIN_IN))[*5]
      |-> (NAND_STATUS_OUT == READY_WAIT_PIN_IN)) else $error("status not pin level");
  chk_rise_flag:
    assert property (!READY_WAIT_PIN_IN[*3] ##1 (READY_WAIT_PIN_IN && !IRQ_RAW_CLEAR_IN[IRQ_WR_BIT])[*5]
      |-> IRQ_RAW_OUT[IRQ_WR_BIT]) else $error("wait rise flag missing");
  chk_read_release:
    assert property (READY_OUT && ACCESS_START_IN && ACCESS_READ_IN |=> !DATA_OE_OUT)
      else $error("bus driven during read");
  chk_timeout_hold:
    assert property ($rose(IRQ_RAW_OUT[IRQ_AT_BIT]) |-> !STROBE_OUT && !READY_OUT)
      else $error("timeout outside hold");
endmodule
bind asws_top asws_asserts chk_u (.*);
`default_nettype wire

// ---- bench/asws_mem_model.sv ----
// wait-capable asynchronous memory at the far side of the block
`timescale 1ns/100ps
`default_nettype none
module asws_mem_model
  import asws_pkg::*;
(
  // strobe side
  input  wire logic              clk_in,
  input  wire logic              strobe_in,
  input  wire logic              oe_in,
  input  wire logic [WORD_W-1:0] word_in,
  // behaviour commanded by the bench
  input  wire logic              pol_in,
  input  wire logic              busy_in,
  input  wire logic [7:0]        wait_len_in,
  input  wire logic [DATA_W-1:0] base_in,
  // memory pins
  output logic                   wait_pin_out,
  output logic [DATA_W-1:0]      rdata_out
);
  logic [7:0]        cnt = 8'h00;     // busy cycles left in this access
  logic [DATA_W-1:0] last = 16'h0000; // last value on the data lines
  logic              strb_q = 1'b0;   // strobe one cycle ago
  // busy count restarts at each strobe start
  always @(posedge clk_in) begin
    strb_q <= strobe_in;
    last <= rdata_out;
    if (strobe_in && !strb_q) cnt <= wait_len_in;
    else if (cnt != 8'h00) cnt <= cnt - 8'h01;
  end
  // busy shows the active level, ready the other one
  assign wait_pin_out = (busy_in || cnt != 8'h00) ? pol_in : !pol_in;
  // released lines toggle, so stale data never passes for a read
  assign rdata_out = (strobe_in && !oe_in) ? base_in + DATA_W'(word_in) : ~last;
endmodule
`default_nettype wire

// ---- bench/asws_top_tb.sv ----
// self-checking bench of the async wait and strobe block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, ac) begin cmp_count++; if ((ex) !== (ac)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h seen %0h", nm, ex, ac); end end
module asws_top_tb;
  import asws_pkg::*;
  // stimulus, changed at falling edges
  logic              clk = 1'b0, rst_n = 1'b0, sm_n = 1'b1, nand_m = 1'b0, pol = 1'b1;
  logic              sr = 1'b0, start = 1'b0, rd = 1'b0, busy = 1'b0;
  logic [7:0]        max_ext = 8'h05, wlen = 8'h00;
  logic [CS_N-1:0]   ew = 4'h0, pre = 4'h0, psz = 4'h0;
  logic [PDEL_W-1:0] pdel = 4'h2;
  logic [CS_W-1:0]   cs = 2'h0;
  logic [STRB_W-1:0] slen = 6'h01;
  logic [DATA_W-1:0] wdata = 16'h0000, base = 16'h0000, din, dout, rdata;
  logic [IRQ_N-1:0]  rclr = 2'h0, eset = 2'h0, eclr = 2'h0, raw, msk, en;
  logic              pin, oe, strobe, ready, done, rvalid, irq, nstat;
  logic [CS_N-1:0]   csel;
  logic [WORD_W-1:0] pword;
  int                num_errors = 0, cmp_count = 0, nstb, nrd, t;
  asws_top dut_u (.CLOCK_IN(clk), .RESETN_IN(rst_n), .SM_RESETN_IN(sm_n), .READY_WAIT_PIN_IN(pin),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_OUT(oe), .STROBE_OUT(strobe), .CS_SEL_OUT(csel),
    .PAGE_WORD_OUT(pword), .NAND_MODE_IN(nand_m), .WAIT_POLARITY_IN(pol), .MAX_STROBE_EXTENSION_IN(max_ext),
    .EXT_WAIT_ENABLE_IN(ew), .PAGE_READ_ENABLE_IN(pre), .PAGE_SIZE_SEL_IN(psz), .PAGE_ACCESS_DELAY_IN(pdel),
    .SELF_REFRESH_IN(sr), .ACCESS_START_IN(start), .ACCESS_READ_IN(rd), .ACCESS_CS_IN(cs),
    .STROBE_LEN_IN(slen), .WRITE_DATA_IN(wdata), .READY_OUT(ready), .ACCESS_DONE_OUT(done),
    .READ_DATA_OUT(rdata), .READ_VALID_OUT(rvalid), .IRQ_RAW_CLEAR_IN(rclr), .IRQ_ENABLE_SET_IN(eset),
    .IRQ_ENABLE_CLEAR_IN(eclr), .IRQ_RAW_OUT(raw), .IRQ_MASKED_OUT(msk), .IRQ_ENABLE_OUT(en),
    .IRQ_OUT(irq), .NAND_STATUS_OUT(nstat));
  asws_mem_model mem_u (.clk_in(clk), .strobe_in(strobe), .oe_in(oe), .word_in(pword), .pol_in(pol),
    .busy_in(busy), .wait_len_in(wlen), .base_in(base), .wait_pin_out(pin), .rdata_out(din));
  always #25 clk = ~clk;
  // verdict and end of run
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  // wait for ready, count done pulses
  task automatic wait_ready();
    t = 0;
    nstb = 0;
    while (ready !== 1'b1 && t < 40) begin
      @(negedge clk);
      t++;
      nstb += int'(done === 1'b1);
    end
  endtask
  // one access, every read word checked
  task automatic access(input logic r, input logic [CS_W-1:0] c, input logic [STRB_W-1:0] l);
    {rd, cs, slen, wdata, base} = {r, c, l, 16'($urandom), 16'($urandom)};
    start = 1'b1;
    @(negedge clk);
    {start, nstb, nrd, t} = {1'b0, 96'h0};
    while (done !== 1'b1 && t < 300) begin
      nstb += int'(strobe === 1'b1);
      if (strobe === 1'b1) `CHK("csel", CS_N'(1) << c, csel)
      if (rvalid === 1'b1) begin
        `CHK("rword", base + DATA_W'(nrd), rdata)
        nrd++;
      end
      @(negedge clk);
      t++;
    end
    num_errors += int'(t >= 300);
  endtask
  // pin low then high
  task automatic rise();
    busy = !pol;
    repeat (6) @(negedge clk);
    busy = pol;
    repeat (6) @(negedge clk);
  endtask
  initial begin
    void'($urandom(37889));
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    wait_ready();
    repeat (8) begin
      access(1'b0, CS_W'($urandom), STRB_W'($urandom_range(0, 4)));
      `CHK("slen", (slen == 0) ? 1 : int'(slen), nstb)
      `CHK("park", wdata, dout)
      access(1'b1, CS_W'($urandom), STRB_W'($urandom_range(1, 4)));
      `CHK("words", 1, nrd)
      `CHK("reparked", 1'b1, oe)
    end
    $display("basic accesses done");
    ew = 4'hF;
    for (int p = 0; p < 2; p++) begin
      {pol, busy} = {p[0], 1'b0};
      access(1'b0, 2'h1, 6'h03);
      `CHK("noext", 3, nstb)
      busy = 1'b1;
      access(1'b1, 2'h1, 6'h03);
      `CHK("tolen", 3 + 5 + 1, nstb)
      `CHK("toflag", 1'b1, raw[IRQ_AT_BIT])
      {max_ext, wlen, rclr, busy} = {8'h0A, 8'h06, 2'h3, 1'b0};
      @(negedge clk);
      rclr = 2'h0;
      access(1'b0, 2'h1, 6'h06);
      `CHK("stretch", 1'b1, nstb > 6)
      `CHK("noto", 1'b0, raw[IRQ_AT_BIT])
      {max_ext, wlen} = {8'h05, 8'h00};
    end
    $display("extended wait done");
    {ew, pre, pdel} = {4'h0, 4'h4, PDEL_W'($urandom_range(0, 3))};
    for (int s = 0; s < 2; s++) begin
      psz = {4{s[0]}};
      access(1'b1, 2'h2, 6'h02);
      `CHK("pwords", (s == 1) ? 8 : 4, nrd)
    end
    {pre, sr} = {4'h0, 1'b1};
    access(1'b1, 2'h0, 6'h02);
    `CHK("srfloat", 1'b0, oe)
    sr = 1'b0;
    access(1'b0, 2'h3, 6'h01);
    `CHK("repark", 1'b1, oe)
    $display("page and parking done");
    {nand_m, pol, rclr, eset} = {1'b1, 1'($urandom), 2'h3, 2'h1};
    @(negedge clk);
    {rclr, eset} = 4'h0;
    rise();
    `CHK("status", 1'b1, nstat)
    `CHK("wrraw", 1'b1, raw[IRQ_WR_BIT])
    `CHK("msk", 5'h15, {irq, msk, en})
    {rclr, eclr} = 4'h5;
    @(negedge clk);
    {rclr, eclr} = 4'h0;
    `CHK("cleared", 6'h00, {raw, msk, en})
    rise();
    `CHK("rawonly", 3'h4, {raw[IRQ_WR_BIT], msk})
    $display("interrupts done");
    {eset, rd, slen, start} = {2'h2, 1'b1, 6'h20, 1'b1};
    @(negedge clk);
    {start, eset} = 3'h0;
    repeat (4) @(negedge clk);
    sm_n = 1'b0;
    @(negedge clk);
    sm_n = 1'b1;
    wait_ready();
    `CHK("smlen", INIT_LAST+1, t)
    `CHK("nodone", 0, nstb)
    `CHK("smkeep", {2'h2, wdata}, {en, dout})
    rst_n = 1'b0;
    @(negedge clk);
    `CHK("hard", 20'h0, {en, raw, dout})
    rst_n = 1'b1;
    wait_ready();
    `CHK("hardlen", INIT_LAST+1, t)
    `CHK("norise", 2'h0, raw)
    $display("resets done");
    complete_run();
  end
endmodule
`default_nettype wire
